// File: mciu_top.sv
// Interrupt unit of an 8-bit core: flags, enables, priority, vectoring.
// Assumes the sequencer pulses cycle_end once per machine cycle and
// call_done when the inserted long call starts.
//
// The AXI4-Lite register port was chosen for this implementation.

// Overview of operation
// - Eleven sources, four priority levels each
// - Accepted request vectors to its fixed address
// - Only strictly higher priority preempts service
// - Return ends service, restores previous level
// - Flags set regardless of enable bits
// - Flags sampled and polled each machine cycle
// - Pending request inserts long call next
// - Withhold when equal or higher in service
// - Defer after return or control writes
// - Global gate bit blocks all acceptance
// - First enable register individual bits
// - Second enable register external inputs two-six
// - Third enable register serial channel one
// - Timer control holds four flags
// - Sense bits: zero level, one falling
// - Polarity bits: zero falling, one rising
// - Request register flags sticky until cleared
// - Timer flags cleared by service acknowledges
// - Edge-sensed external flags cleared on vectoring
// - Two priority bits per group
// - Fixed polling order breaks ties
module mciu_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Event sources
    input wire logic ext_in_a_n,
    input wire logic ext_in_b_n,
    input wire logic [4:0] ext_in_cg,
    input wire logic timer_a_ovf,
    input wire logic timer_b_ovf,
    input wire logic serial_a_req,
    input wire logic serial_b_req,
    // Core sequencer
    input wire mciu_pkg::mciu_core_s core_in,
    output mciu_pkg::mciu_call_s call_out,
    output logic timer_a_service_ack,
    output logic timer_b_service_ack,
    output logic [3:0] in_service
);
    logic rst_s1_r, rstn_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rstn_r <= rst_s1_r;
        end
    end

    function automatic logic [7:0] wmerge(input logic [7:0] old,
        input logic [7:0] d, input logic [7:0] m);
        wmerge = (old & ~m) | (d & m);
    endfunction

    // Register state
    logic [7:0] en1_r, en1_nxt, en2_r, en2_nxt, en3_r, en3_nxt;
    logic [7:0] prl_r, prl_nxt, prh_r, prh_nxt, pol_r, pol_nxt;
    logic [7:0] tctl_r, tctl_nxt, req_r, req_nxt;
    logic [3:0] stack_r, stack_nxt;
    logic [3:0] src_r, src_nxt;
    logic call_r, call_nxt;
    logic xa_d_r, xb_d_r;
    logic [4:0] xcg_d_r;
    // Bus state
    logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_r, bv_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [mciu_pkg::NSRC-1:0] samp_r, samp_nxt;

    assign s_awready = !aw_ok_r && !bv_r;
    assign s_wready = !w_ok_r && !bv_r;
    assign s_bvalid = bv_r;
    assign s_bresp = br_r;
    assign s_arready = !rv_r;
    assign s_rvalid = rv_r;
    assign s_rdata = rd_r;
    assign s_rresp = rr_r;

    logic do_wr;
    assign do_wr = aw_ok_r && w_ok_r && !bv_r;

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == mciu_pkg::REG_TCTL_A || a == mciu_pkg::REG_EN3_A ||
            a == mciu_pkg::REG_EN1_A || a == mciu_pkg::REG_PRL_A ||
            a == mciu_pkg::REG_EN2_A || a == mciu_pkg::REG_PRH_A ||
            a == mciu_pkg::REG_REQ_A || a == mciu_pkg::REG_POL_A;
    endfunction

    // Edge detection on external inputs
    logic xa_fall, xb_fall;
    logic [4:0] xcg_ev;
    assign xa_fall = xa_d_r && !ext_in_a_n;
    assign xb_fall = xb_d_r && !ext_in_b_n;
    always_comb begin
        xcg_ev = ext_in_cg & ~xcg_d_r;
        if (!pol_r[mciu_pkg::XC_POL_B]) begin
            xcg_ev[0] = !ext_in_cg[0] && xcg_d_r[0];
        end
        if (!pol_r[mciu_pkg::XD_POL_B]) begin
            xcg_ev[1] = !ext_in_cg[1] && xcg_d_r[1];
        end
    end

    // Level view of all requests in polling order
    logic [mciu_pkg::NSRC-1:0] flags, enables;
    always_comb begin
        flags = '0;
        flags[mciu_pkg::SRC_XA] = tctl_r[mciu_pkg::XA_FLAG_B];
        flags[mciu_pkg::SRC_SB] = serial_b_req;
        flags[mciu_pkg::SRC_TA] = tctl_r[mciu_pkg::TA_OVF_B];
        flags[mciu_pkg::SRC_XC] = req_r[1];
        flags[mciu_pkg::SRC_XB] = tctl_r[mciu_pkg::XB_FLAG_B];
        flags[mciu_pkg::SRC_XD] = req_r[2];
        flags[mciu_pkg::SRC_TB] = tctl_r[mciu_pkg::TB_OVF_B];
        flags[mciu_pkg::SRC_XE] = req_r[3];
        flags[mciu_pkg::SRC_SA] = serial_a_req;
        flags[mciu_pkg::SRC_XF] = req_r[4];
        flags[mciu_pkg::SRC_XG] = req_r[5];
        enables = '0;
        enables[mciu_pkg::SRC_XA] = en1_r[0];
        enables[mciu_pkg::SRC_TA] = en1_r[1];
        enables[mciu_pkg::SRC_XB] = en1_r[2];
        enables[mciu_pkg::SRC_TB] = en1_r[3];
        enables[mciu_pkg::SRC_SA] = en1_r[4];
        enables[mciu_pkg::SRC_SB] = en3_r[0];
        enables[mciu_pkg::SRC_XC] = en2_r[1];
        enables[mciu_pkg::SRC_XD] = en2_r[2];
        enables[mciu_pkg::SRC_XE] = en2_r[3];
        enables[mciu_pkg::SRC_XF] = en2_r[4];
        enables[mciu_pkg::SRC_XG] = en2_r[5];
    end

    // Priority level of each source
    logic [1:0] lvl [mciu_pkg::NSRC];
    genvar gi;
    generate
        for (gi = 0; gi < mciu_pkg::NSRC; gi++) begin : g_lvl
            assign lvl[gi] = {prh_r[mciu_pkg::GRP_OF[gi]],
                prl_r[mciu_pkg::GRP_OF[gi]]};
        end
    endgenerate

    // Arbitration over the sampled flags
    logic win_ok;
    logic [3:0] win_src;
    logic [1:0] win_lvl;
    logic [2:0] cur_lvl; // 4 = idle, else active level
    always_comb begin
        cur_lvl = 3'd4;
        for (int l = 0; l < 4; l++) begin
            if (stack_r[l]) begin
                cur_lvl = 3'(l);
            end
        end
        win_ok = 1'b0;
        win_src = '0;
        win_lvl = '0;
        for (int l = 0; l < 4; l++) begin
            for (int s = mciu_pkg::NSRC - 1; s >= 0; s--) begin
                if (samp_r[s] && lvl[s] == 2'(l)) begin
                    win_ok = 1'b1;
                    win_src = 4'(s);
                    win_lvl = 2'(l);
                end
            end
        end
    end
    // Later levels overwrite, so the winner is highest level, first polled

    logic can_take;
    assign can_take = win_ok && en1_r[mciu_pkg::GATE_B] &&
        (cur_lvl == 3'd4 || 3'(win_lvl) > cur_lvl) &&
        !core_in.ins_ret && !core_in.ins_ctl_wr &&
        core_in.cycle_end && !call_r;

    always_comb begin
        samp_nxt = samp_r;
        if (core_in.cycle_end) begin
            samp_nxt = flags & enables;
        end
        call_nxt = call_r;
        src_nxt = src_r;
        stack_nxt = stack_r;
        if (can_take) begin
            call_nxt = 1'b1;
            src_nxt = win_src;
        end else if (call_r && core_in.call_done) begin
            call_nxt = 1'b0;
            stack_nxt[lvl[src_r]] = 1'b1;
        end
        if (core_in.ins_ret && !call_r) begin
            if (cur_lvl != 3'd4) begin
                stack_nxt[cur_lvl[1:0]] = 1'b0;
            end
        end
    end

    logic ack;
    assign ack = call_r && core_in.call_done;
    assign timer_a_service_ack = ack && src_r == mciu_pkg::SRC_TA;
    assign timer_b_service_ack = ack && src_r == mciu_pkg::SRC_TB;
    assign call_out.call_req = call_r;
    assign call_out.src = src_r;
    assign call_out.vector = mciu_pkg::VEC_BASE +
        16'(src_r) * mciu_pkg::VEC_STEP;
    assign in_service = stack_r;

    // Register and bus next state
    always_comb begin
        en1_nxt = en1_r;
        en2_nxt = en2_r;
        en3_nxt = en3_r;
        prl_nxt = prl_r;
        prh_nxt = prh_r;
        pol_nxt = pol_r;
        tctl_nxt = tctl_r;
        req_nxt = req_r;
        aw_ok_nxt = aw_ok_r || (s_awvalid && s_awready);
        w_ok_nxt = w_ok_r || (s_wvalid && s_wready);
        awa_nxt = (s_awvalid && s_awready) ? s_awaddr : awa_r;
        wd_nxt = (s_wvalid && s_wready && s_wstrb[0]) ? s_wdata[7:0] : wd_r;
        if (s_wvalid && s_wready && !s_wstrb[0]) begin
            wd_nxt = 8'hff;
        end
        bv_nxt = bv_r && !s_bready;
        br_nxt = br_r;
        if (do_wr) begin
            aw_ok_nxt = 1'b0;
            w_ok_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = mapped(awa_r) ? mciu_pkg::AXI_OKAY : mciu_pkg::AXI_SLVERR;
            case (awa_r)
                mciu_pkg::REG_EN1_A: en1_nxt = wmerge(en1_r, wd_r,
                    mciu_pkg::EN1_MASK);
                mciu_pkg::REG_EN2_A: en2_nxt = wmerge(en2_r, wd_r,
                    mciu_pkg::EN2_MASK);
                mciu_pkg::REG_EN3_A: en3_nxt = wmerge(en3_r, wd_r,
                    mciu_pkg::EN3_MASK);
                mciu_pkg::REG_PRL_A: prl_nxt = wmerge(prl_r, wd_r,
                    mciu_pkg::PRI_MASK);
                mciu_pkg::REG_PRH_A: prh_nxt = wmerge(prh_r, wd_r,
                    mciu_pkg::PRI_MASK);
                mciu_pkg::REG_POL_A: pol_nxt = wmerge(pol_r, wd_r,
                    mciu_pkg::POL_MASK);
                mciu_pkg::REG_TCTL_A: tctl_nxt = wd_r;
                mciu_pkg::REG_REQ_A: req_nxt = wmerge(req_r, wd_r,
                    mciu_pkg::REQ_MASK);
                default: begin
                end
            endcase
        end
        // Service clears, then hardware sets win
        if (ack) begin
            case (src_r)
                mciu_pkg::SRC_TA: tctl_nxt[mciu_pkg::TA_OVF_B] = 1'b0;
                mciu_pkg::SRC_TB: tctl_nxt[mciu_pkg::TB_OVF_B] = 1'b0;
                mciu_pkg::SRC_XA: tctl_nxt[mciu_pkg::XA_FLAG_B] = 1'b0;
                mciu_pkg::SRC_XB: tctl_nxt[mciu_pkg::XB_FLAG_B] = 1'b0;
                mciu_pkg::SRC_XC: req_nxt[1] = 1'b0;
                mciu_pkg::SRC_XD: req_nxt[2] = 1'b0;
                mciu_pkg::SRC_XE: req_nxt[3] = 1'b0;
                mciu_pkg::SRC_XF: req_nxt[4] = 1'b0;
                mciu_pkg::SRC_XG: req_nxt[5] = 1'b0;
                default: begin
                end
            endcase
        end
        if (timer_a_ovf) tctl_nxt[mciu_pkg::TA_OVF_B] = 1'b1;
        if (timer_b_ovf) tctl_nxt[mciu_pkg::TB_OVF_B] = 1'b1;
        // Level mode: flag follows the pin, so it returns after service
        if (!tctl_r[mciu_pkg::XA_SENSE_B]) begin
            tctl_nxt[mciu_pkg::XA_FLAG_B] = !ext_in_a_n;
        end else if (xa_fall) begin
            tctl_nxt[mciu_pkg::XA_FLAG_B] = 1'b1;
        end
        if (!tctl_r[mciu_pkg::XB_SENSE_B]) begin
            tctl_nxt[mciu_pkg::XB_FLAG_B] = !ext_in_b_n;
        end else if (xb_fall) begin
            tctl_nxt[mciu_pkg::XB_FLAG_B] = 1'b1;
        end
        req_nxt[5:1] = req_nxt[5:1] | xcg_ev;
        req_nxt = req_nxt & mciu_pkg::REQ_MASK;
        // Read channel
        rv_nxt = rv_r && !s_rready;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (s_arvalid && s_arready) begin
            rv_nxt = 1'b1;
            rr_nxt = mapped(s_araddr) ? mciu_pkg::AXI_OKAY :
                mciu_pkg::AXI_SLVERR;
            case (s_araddr)
                mciu_pkg::REG_EN1_A: rd_nxt = {24'h0, en1_r};
                mciu_pkg::REG_EN2_A: rd_nxt = {24'h0, en2_r};
                mciu_pkg::REG_EN3_A: rd_nxt = {24'h0, en3_r};
                mciu_pkg::REG_PRL_A: rd_nxt = {24'h0, prl_r};
                mciu_pkg::REG_PRH_A: rd_nxt = {24'h0, prh_r};
                mciu_pkg::REG_POL_A: rd_nxt = {24'h0, pol_r};
                mciu_pkg::REG_TCTL_A: rd_nxt = {24'h0, tctl_r};
                mciu_pkg::REG_REQ_A: rd_nxt = {24'h0, req_r};
                default: rd_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn_r) begin
        if (!rstn_r) begin
            en1_r <= mciu_pkg::REG_RST;
            en2_r <= mciu_pkg::REG_RST;
            en3_r <= mciu_pkg::REG_RST;
            prl_r <= mciu_pkg::REG_RST;
            prh_r <= mciu_pkg::REG_RST;
            pol_r <= mciu_pkg::REG_RST;
            tctl_r <= mciu_pkg::REG_RST;
            req_r <= mciu_pkg::REG_RST;
            stack_r <= '0;
            src_r <= '0;
            call_r <= 1'b0;
            samp_r <= '0;
            xa_d_r <= 1'b1;
            xb_d_r <= 1'b1;
            xcg_d_r <= '0;
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            bv_r <= 1'b0;
            awa_r <= '0;
            wd_r <= '0;
            rv_r <= 1'b0;
            rd_r <= '0;
            br_r <= '0;
            rr_r <= '0;
        end else begin
            en1_r <= en1_nxt;
            en2_r <= en2_nxt;
            en3_r <= en3_nxt;
            prl_r <= prl_nxt;
            prh_r <= prh_nxt;
            pol_r <= pol_nxt;
            tctl_r <= tctl_nxt;
            req_r <= req_nxt;
            stack_r <= stack_nxt;
            src_r <= src_nxt;
            call_r <= call_nxt;
            samp_r <= samp_nxt;
            xa_d_r <= ext_in_a_n;
            xb_d_r <= ext_in_b_n;
            xcg_d_r <= ext_in_cg;
            aw_ok_r <= aw_ok_nxt;
            w_ok_r <= w_ok_nxt;
            bv_r <= bv_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            br_r <= br_nxt;
            rr_r <= rr_nxt;
        end
    end

    // Checks
    a_gate_blocks: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        !en1_r[mciu_pkg::GATE_B] |=> !$rose(call_r))
        else $error("call raised with gate closed");
    a_defer_ret: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        (core_in.ins_ret || core_in.ins_ctl_wr) && !call_r |=> !call_r)
        else $error("call during deferred instruction");
    a_no_equal_pre: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        $rose(call_r) && $past(cur_lvl) != 3'd4 |->
        3'(lvl[src_r]) > $past(cur_lvl))
        else $error("preempt without higher level");
    a_call_hold: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        call_r && !core_in.call_done |=> call_r && $stable(src_r))
        else $error("call dropped before done");
    a_ta_ack: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        timer_a_service_ack && !timer_a_ovf |=>
        !tctl_r[mciu_pkg::TA_OVF_B])
        else $error("timer a flag not cleared");
    a_ovf_set: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        timer_b_ovf |=> tctl_r[mciu_pkg::TB_OVF_B])
        else $error("timer b flag not set");
    a_level_req: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        !tctl_r[mciu_pkg::XA_SENSE_B] && !ext_in_a_n |=>
        tctl_r[mciu_pkg::XA_FLAG_B])
        else $error("level request lost");
    a_ret_pop: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        core_in.ins_ret && !call_r && cur_lvl != 3'd4 |=>
        !stack_r[$past(cur_lvl[1:0])])
        else $error("return did not end service");
    a_vec_slot: assert property (
        @(posedge sys_clk) disable iff (!rstn_r)
        call_r |-> call_out.vector[2:0] == mciu_pkg::VEC_BASE[2:0])
        else $error("vector off its slot");
    c_take: cover property (@(posedge sys_clk) disable iff (!rstn_r)
        $rose(call_r));
    c_nest: cover property (@(posedge sys_clk) disable iff (!rstn_r)
        $rose(call_r) && $past(cur_lvl) != 3'd4);
    c_ret: cover property (@(posedge sys_clk) disable iff (!rstn_r)
        core_in.ins_ret && cur_lvl != 3'd4);
endmodule

// File: mciu_pkg.sv
// Package for the core interrupt unit: register map, fields, sources.
// Assumes a 32-bit AXI4-Lite master and a core sequencer handshake.
package mciu_pkg;
    // Register byte addresses (printed offsets)
    localparam logic [7:0] REG_TCTL_A = 8'h88;
    localparam logic [7:0] REG_EN3_A = 8'h9a;
    localparam logic [7:0] REG_EN1_A = 8'ha8;
    localparam logic [7:0] REG_PRL_A = 8'ha9;
    localparam logic [7:0] REG_EN2_A = 8'hb8;
    localparam logic [7:0] REG_PRH_A = 8'hb9;
    localparam logic [7:0] REG_REQ_A = 8'hc0;
    localparam logic [7:0] REG_POL_A = 8'hc8;
    // Field positions
    localparam int GATE_B = 7;
    localparam int TB_OVF_B = 7;
    localparam int TA_OVF_B = 5;
    localparam int XB_FLAG_B = 3;
    localparam int XB_SENSE_B = 2;
    localparam int XA_FLAG_B = 1;
    localparam int XA_SENSE_B = 0;
    localparam int XD_POL_B = 6;
    localparam int XC_POL_B = 5;
    // Writable masks and reset values
    localparam logic [7:0] EN1_MASK = 8'hdf;
    localparam logic [7:0] EN2_MASK = 8'h3e;
    localparam logic [7:0] EN3_MASK = 8'h01;
    localparam logic [7:0] PRI_MASK = 8'h3f;
    localparam logic [7:0] POL_MASK = 8'h60;
    localparam logic [7:0] REQ_MASK = 8'h3e;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int NSRC = 11;
    localparam int NGRP = 6;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // Sources in polling order (index 0 polled first)
    typedef enum logic [3:0] {
        SRC_XA, SRC_SB, SRC_TA, SRC_XC, SRC_XB, SRC_XD,
        SRC_TB, SRC_XE, SRC_SA, SRC_XF, SRC_XG
    } mciu_src_e;
    // Priority group of each source, by polling index
    localparam logic [2:0] GRP_OF [NSRC] = '{
        3'd0, 3'd0, 3'd1, 3'd1, 3'd2, 3'd2, 3'd3, 3'd3, 3'd4, 3'd4, 3'd5};
    // Vector slot, one per source
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // Core handshake toward the sequencer
    typedef struct packed {
        logic cycle_end;
        logic ins_ret;
        logic ins_ctl_wr;
        logic call_done;
    } mciu_core_s;
    typedef struct packed {
        logic call_req;
        logic [15:0] vector;
        logic [3:0] src;
    } mciu_call_s;
endpackage

// File: mciu_core_model.sv
// Partner model: core sequencer machine cycles, returns, call insertion.
// Assumes the bench drives ret_go, ctl_wr_go and ack_dly after clock edges.
module mciu_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Bench commands
    input wire logic ret_go,
    input wire logic ctl_wr_go,
    input wire logic [1:0] ack_dly,
    // Unit handshake
    input wire mciu_pkg::mciu_call_s call_out,
    output mciu_pkg::mciu_core_s core_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase, wcnt;
    logic pend;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 2'h0;
            wcnt <= 2'h0;
            pend <= 1'b0;
            core_in <= '0;
        end else begin
            phase <= phase + 2'h1;
            // One machine cycle per four clocks
            core_in.cycle_end <= phase == 2'h3;
            // Return lasts one clock, ending with its machine cycle
            core_in.ins_ret <= phase == 2'h3 && (pend || ret_go);
            pend <= (pend || ret_go) && phase != 2'h3;
            core_in.ins_ctl_wr <= ctl_wr_go;
            core_in.call_done <= 1'b0;
            if (call_out.call_req && !core_in.call_done) begin
                wcnt <= wcnt == ack_dly ? 2'h0 : wcnt + 2'h1;
                core_in.call_done <= wcnt == ack_dly;
            end
        end
    end
endmodule

// File: mciu_top_bench.sv
// Self-checking bench for the interrupt unit with a sequencer model.
// Assumes the register map and vector slots of mciu_pkg.
module mciu_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, resetn, s_awvalid, s_wvalid, s_bready, s_arvalid;
    logic s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb, in_service;
    logic [1:0] s_bresp, s_rresp, ack_dly;
    logic ext_in_a_n, ext_in_b_n, timer_a_ovf, timer_b_ovf;
    logic serial_a_req, serial_b_req, ret_go, ctl_wr_go;
    logic timer_a_service_ack, timer_b_service_ack;
    logic [4:0] ext_in_cg;
    mciu_pkg::mciu_core_s core_in;
    mciu_pkg::mciu_call_s call_out;
    int miscompares, comparisons;
    int unsigned seed_v, rv;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    logic [21:0] cq[$];
    localparam logic [1:0] OK = mciu_pkg::AXI_OKAY;
    localparam logic [7:0] RA [8] = '{mciu_pkg::REG_EN1_A,
        mciu_pkg::REG_EN2_A, mciu_pkg::REG_EN3_A, mciu_pkg::REG_PRL_A,
        mciu_pkg::REG_PRH_A, mciu_pkg::REG_POL_A, mciu_pkg::REG_TCTL_A,
        mciu_pkg::REG_REQ_A};
    localparam logic [7:0] RM [6] = '{mciu_pkg::EN1_MASK,
        mciu_pkg::EN2_MASK, mciu_pkg::EN3_MASK, mciu_pkg::PRI_MASK,
        mciu_pkg::PRI_MASK, mciu_pkg::POL_MASK};

    mciu_top uut (.sys_clk, .resetn, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .ext_in_a_n, .ext_in_b_n, .ext_in_cg,
        .timer_a_ovf, .timer_b_ovf, .serial_a_req, .serial_b_req,
        .core_in, .call_out, .timer_a_service_ack, .timer_b_service_ack,
        .in_service);
    mciu_core_model model (.sys_clk, .resetn, .ret_go, .ctl_wr_go,
        .ack_dly, .call_out, .core_in);

    always #50 sys_clk = ~sys_clk;

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic note(input string n, input logic [35:0] e, s);
        comparisons++;
        if (e !== s) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic logic [21:0] ecall(input logic [3:0] s);
        return {s, mciu_pkg::VEC_BASE + mciu_pkg::VEC_STEP * 16'(s),
            s == 4'(mciu_pkg::SRC_TB), s == 4'(mciu_pkg::SRC_TA)};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge sys_clk);
        wq.push_back(r);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge sys_clk);
        rq.push_back(e);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        s_rready <= 1'b0;
    endtask

    task automatic wait_is(input logic [3:0] v);
        int n;
        n = 0;
        while (in_service !== v && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        note("in_service", 36'(v), 36'(in_service));
    endtask

    task automatic ret_to(input logic [3:0] v);
        @(posedge sys_clk);
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
        wait_is(v);
    endtask

    // Results are matched in order against the oldest expectation
    always @(posedge sys_clk) begin
        if (s_rvalid && s_rready)
            note("rdata", 36'(rq.size() ? rq.pop_front() : '1),
                36'({s_rresp, s_rdata}));
        if (s_bvalid && s_bready)
            note("bresp", 36'(wq.size() ? wq.pop_front() : 2'b11),
                36'(s_bresp));
        if (call_out.call_req && core_in.call_done)
            note("call", 36'(cq.size() ? cq.pop_front() : '1),
                36'({call_out.src, call_out.vector, timer_b_service_ack,
                timer_a_service_ack}));
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hf;
        {timer_a_ovf, timer_b_ovf, serial_a_req, serial_b_req} = '0;
        {ret_go, ctl_wr_go, ack_dly} = '0;
        {ext_in_a_n, ext_in_b_n, ext_in_cg} = 7'h63;
        seed_v = $urandom(72216);
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
            rd(RA[i], {OK, 24'h0, mciu_pkg::REG_RST});
        for (int i = 0; i < 6; i++) begin
            rv = $urandom;
            wr(RA[i], rv, OK);
            rd(RA[i], {OK, 24'h0, rv[7:0] & RM[i]});
            wr(RA[i], 32'h0, OK);
        end
        wr(8'h10, rv, mciu_pkg::AXI_SLVERR);
        rd(8'h10, {mciu_pkg::AXI_SLVERR, 32'h0});
        // All sources raised with every enable off
        wr(mciu_pkg::REG_TCTL_A, 32'h05, OK);
        {ext_in_a_n, ext_in_b_n, timer_a_ovf, timer_b_ovf, ext_in_cg} <= 9'h07c;
        @(posedge sys_clk);
        {ext_in_a_n, ext_in_b_n, timer_a_ovf, timer_b_ovf} <= 4'b1100;
        {serial_a_req, serial_b_req} <= 2'b11;
        rd(mciu_pkg::REG_TCTL_A, {OK, 32'haf});
        rd(mciu_pkg::REG_REQ_A, {OK, 32'h3e});
        wr(mciu_pkg::REG_EN1_A, 32'h1f, OK);
        wr(mciu_pkg::REG_EN2_A, 32'h3e, OK);
        wr(mciu_pkg::REG_EN3_A, 32'h01, OK);
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < mciu_pkg::NSRC; i++)
            cq.push_back(ecall(4'(i)));
        wr(mciu_pkg::REG_EN1_A, 32'h9f, OK);
        for (int i = 0; i < mciu_pkg::NSRC; i++) begin
            wait_is(4'b0001);
            if (i == int'(mciu_pkg::SRC_SB)) serial_b_req <= 1'b0;
            if (i == int'(mciu_pkg::SRC_SA)) serial_a_req <= 1'b0;
            ack_dly <= 2'($urandom);
            ret_to(4'b0000);
        end
        rd(mciu_pkg::REG_TCTL_A, {OK, 32'h05});
        rd(mciu_pkg::REG_REQ_A, {OK, 32'h00});
        // Preemption by a strictly higher group only
        wr(mciu_pkg::REG_PRL_A, 32'h08, OK);
        wr(mciu_pkg::REG_PRH_A, 32'h08, OK);
        wr(mciu_pkg::REG_POL_A, 32'h20, OK);
        cq.push_back(ecall(4'(mciu_pkg::SRC_XC)));
        ext_in_cg[1:0] <= 2'b01;
        wait_is(4'b0001);
        cq.push_back(ecall(4'(mciu_pkg::SRC_TB)));
        timer_b_ovf <= 1'b1;
        @(posedge sys_clk);
        timer_b_ovf <= 1'b0;
        wait_is(4'b1001);
        ext_in_cg[1] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        ext_in_cg[1] <= 1'b0;
        repeat (20) @(posedge sys_clk);
        ret_to(4'b0001);
        cq.push_back(ecall(4'(mciu_pkg::SRC_XD)));
        ret_to(4'b0000);
        wait_is(4'b0001);
        ret_to(4'b0000);
        // Low level keeps requesting while held
        wr(mciu_pkg::REG_TCTL_A, 32'h00, OK);
        cq.push_back(ecall(4'(mciu_pkg::SRC_XA)));
        cq.push_back(ecall(4'(mciu_pkg::SRC_XA)));
        ext_in_a_n <= 1'b0;
        wait_is(4'b0001);
        ret_to(4'b0000);
        wait_is(4'b0001);
        ext_in_a_n <= 1'b1;
        ret_to(4'b0000);
        // Acceptance held off during a control write
        ctl_wr_go <= 1'b1;
        wr(mciu_pkg::REG_EN1_A, 32'h83, OK);
        timer_a_ovf <= 1'b1;
        @(posedge sys_clk);
        timer_a_ovf <= 1'b0;
        repeat (20) @(posedge sys_clk);
        cq.push_back(ecall(4'(mciu_pkg::SRC_TA)));
        ctl_wr_go <= 1'b0;
        wait_is(4'b0001);
        ret_to(4'b0000);
        rd(mciu_pkg::REG_TCTL_A, {OK, 32'h00});
        complete_run();
    end
endmodule
